// file: include/jtpe_pkg.sv
package jtpe_pkg;

	// -----------------------------------------------------------------
	// Test access port controller states
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE = 4'h1,
		ST_SEL_DR = 4'h2,
		ST_CAP_DR = 4'h3,
		ST_SH_DR = 4'h4,
		ST_EX1_DR = 4'h5,
		ST_PAU_DR = 4'h6,
		ST_EX2_DR = 4'h7,
		ST_UPD_DR = 4'h8,
		ST_SEL_IR = 4'h9,
		ST_CAP_IR = 4'hA,
		ST_SH_IR = 4'hB,
		ST_EX1_IR = 4'hC,
		ST_PAU_IR = 4'hD,
		ST_EX2_IR = 4'hE,
		ST_UPD_IR = 4'hF
	} jtpe_state_t;

	// -----------------------------------------------------------------
	// Register sizes, capture and reset values
	// -----------------------------------------------------------------
	localparam int IR_WIDTH = 4;
	localparam int DR_WIDTH = 8;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] IR_RESET = 4'hF;
	// Instruction that selects the emulation pin direction register.
	localparam logic [3:0] IR_EMU_DIR = 4'h2;
	// Instruction that selects the one-bit bypass register.
	localparam logic [3:0] IR_BYPASS = 4'hF;
	localparam logic [7:0] DR_RESET = 8'h00;
	// Number of flip-flops in each pin synchroniser.
	localparam int SYNC_STAGES = 2;

endpackage : jtpe_pkg

// file: hdl/jtpe_sync.sv
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Two-flop synchroniser for a group of pin inputs
// -----------------------------------------------------------------
module jtpe_sync
	import jtpe_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Asynchronous pins and their synchronised copies.
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);

	// First stage is read only by the second stage.
	logic [WIDTH-1:0] meta;

	// Both stages reset to zero; the pins are sampled once per clock.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta <= '0;
			pinOut <= '0;
		end
		else
		begin
			meta <= pinIn;
			pinOut <= meta;
		end
	end

endmodule : jtpe_sync

// file: hdl/jtpe_tap.sv
// Behaviour
// - TMS steps state on rising TCK.
// - TDI shifts into selected register on rise.
// - TDO changes on falling TCK edge.
// - Emulation pins bidirectional while TRST high.
// - Pin a high, b low at TRST rise: boundary scan.
// - Pin a 0, b 1 at reset exit: hold.
// - Hold mode suspends the bootloader.
// - TRST low means functional mode, scan ignored.
`timescale 1ns/1ps

module jtpe_tap
	import jtpe_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Test port pins from the probe.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst,
	// Test data out.
	output logic tdo,
	output logic tdoEn,
	// Emulation pin a, split into input, output and enable.
	input wire logic debug_event_pin_a_in,
	output logic debug_event_pin_a_out,
	output logic debug_event_pin_a_oe,
	// Emulation pin b, split into input, output and enable.
	input wire logic debug_event_pin_b_in,
	output logic debug_event_pin_b_out,
	output logic debug_event_pin_b_oe,
	// Core-side debug interrupt lines.
	input wire logic coreDebugIrqOut,
	output logic coreDebugIrqA,
	output logic coreDebugIrqB,
	// Mode status towards the core.
	output logic boundaryScanMode,
	output logic boot_hold_waiting_mode,
	output logic bootSuspend
);

	// -----------------------------------------------------------------
	// Pin synchronisation
	// -----------------------------------------------------------------
	logic [5:0] syncPins; // Synchronised tck, tms, tdi, trst, pin a and pin b.
	logic [5:0] rawPins; // Pins gathered for the synchroniser.
	assign rawPins = {tck, tms, tdi, trst, debug_event_pin_a_in, debug_event_pin_b_in};

	jtpe_sync #(.WIDTH(6)) uSync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinIn(rawPins),
		.pinOut(syncPins)
	);

	// One plain vector on the port keeps the output connection a single variable.
	wire [4:0] pinSync = syncPins[5:1]; // Synchronised tck, tms, tdi, trst and pin a.
	wire pinBSync = syncPins[0]; // Synchronised pin b.
	wire tckS = pinSync[4]; // Test clock after sync.
	wire tmsS = pinSync[3]; // Mode select after sync.
	wire tdiS = pinSync[2]; // Data in after sync.
	wire trstS = pinSync[1]; // Test reset after sync.
	wire pinAS = pinSync[0]; // Pin a after sync.

	// -----------------------------------------------------------------
	// Edge detection on the sampled test clock and test reset
	// -----------------------------------------------------------------
	logic tckD; // Previous synchronised test clock.
	logic trstD; // Previous synchronised test reset.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tckD <= 1'b0;
			trstD <= 1'b0;
		end
		else
		begin
			tckD <= tckS;
			trstD <= trstS;
		end
	end

	// Edges only count while the scan system owns the port.
	wire tckRise = tckS & ~tckD & trstS;
	wire tckFall = ~tckS & tckD & trstS;
	wire trstRise = trstS & ~trstD;

	// -----------------------------------------------------------------
	// Controller state machine
	// -----------------------------------------------------------------
	jtpe_state_t state;
	jtpe_state_t next_state;

	// Standard next-state table driven by the sampled mode select.
	always_comb
	begin
		unique case (state)
			ST_RESET: next_state = tmsS ? ST_RESET : ST_IDLE;
			ST_IDLE: next_state = tmsS ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: next_state = tmsS ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: next_state = tmsS ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: next_state = tmsS ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: next_state = tmsS ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: next_state = tmsS ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: next_state = tmsS ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: next_state = tmsS ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: next_state = tmsS ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: next_state = tmsS ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: next_state = tmsS ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: next_state = tmsS ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: next_state = tmsS ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: next_state = tmsS ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: next_state = tmsS ? ST_SEL_DR : ST_IDLE;
		endcase
	end

	// State steps on each rising test clock; low test reset forces reset.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= ST_RESET;
		else if (!trstS)
			state <= ST_RESET;
		else if (tckRise)
			state <= next_state;
	end

	// -----------------------------------------------------------------
	// Instruction and data registers
	// -----------------------------------------------------------------
	logic [IR_WIDTH-1:0] irShift; // Instruction shift stage.
	logic [IR_WIDTH-1:0] irHold; // Current instruction.
	logic [DR_WIDTH-1:0] drShift; // Data shift stage.
	logic [1:0] emuDir; // Output enables for pins a and b.
	logic bypassBit; // One-bit bypass register.

	wire selDir = (irHold == IR_EMU_DIR); // Direction register selected.
	wire drLsb = selDir ? drShift[0] : bypassBit; // Serial out of the data path.

	// Capture, shift and update, all on rising test clock edges.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irShift <= IR_RESET;
			irHold <= IR_RESET;
			drShift <= DR_RESET;
			emuDir <= 2'h0;
			bypassBit <= 1'b0;
		end
		else if (!trstS || state == ST_RESET)
		begin
			irHold <= IR_RESET;
			emuDir <= 2'h0;
		end
		else if (tckRise)
		begin
			unique case (state)
				ST_CAP_IR: irShift <= IR_CAPTURE;
				ST_SH_IR: irShift <= {tdiS, irShift[IR_WIDTH-1:1]};
				ST_UPD_IR: irHold <= irShift;
				ST_CAP_DR:
				begin
					drShift <= {6'h00, emuDir};
					bypassBit <= 1'b0;
				end
				ST_SH_DR:
				begin
					drShift <= {tdiS, drShift[DR_WIDTH-1:1]};
					bypassBit <= tdiS;
				end
				ST_UPD_DR: if (selDir) emuDir <= drShift[1:0];
				default: ;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Test data out, changed only on falling test clock edges; low test reset also drops the enable
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tdo <= 1'b0;
			tdoEn <= 1'b0;
		end
		else if (!trstS)
			tdoEn <= 1'b0;
		else if (tckFall)
		begin
			tdo <= (state == ST_SH_IR) ? irShift[0] : drLsb;
			tdoEn <= (state == ST_SH_IR) || (state == ST_SH_DR);
		end
	end

	// -----------------------------------------------------------------
	// Emulation pins and modes
	// -----------------------------------------------------------------
	logic holdSampled; // Hold condition caught at reset release.

	// Pins act as interrupt lines only while the scan system is in control.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			debug_event_pin_a_out <= 1'b0;
			debug_event_pin_a_oe <= 1'b0;
			debug_event_pin_b_out <= 1'b0;
			debug_event_pin_b_oe <= 1'b0;
			coreDebugIrqA <= 1'b0;
			coreDebugIrqB <= 1'b0;
		end
		else
		begin
			debug_event_pin_a_out <= coreDebugIrqOut;
			debug_event_pin_b_out <= coreDebugIrqOut;
			debug_event_pin_a_oe <= trstS & emuDir[0];
			debug_event_pin_b_oe <= trstS & emuDir[1];
			coreDebugIrqA <= trstS & ~emuDir[0] & pinAS;
			coreDebugIrqB <= trstS & ~emuDir[1] & pinBSync;
		end
	end

	// Boundary scan latches on a test reset rise; hold is sampled once after reset.
	// The sample waits for the synchroniser to fill, so it trusts real pin levels.
	logic [1:0] releaseCnt; // Clocks since reset release.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			boundaryScanMode <= 1'b0;
			boot_hold_waiting_mode <= 1'b0;
			bootSuspend <= 1'b0;
			holdSampled <= 1'b0;
			releaseCnt <= 2'h0;
		end
		else
		begin
			if (trstRise && pinAS && !pinBSync)
				boundaryScanMode <= 1'b1;
			if (releaseCnt != 2'h3)
				releaseCnt <= releaseCnt + 2'h1;
			if (releaseCnt == 2'h2 && !holdSampled)
			begin
				holdSampled <= 1'b1;
				boot_hold_waiting_mode <= !pinAS && pinBSync;
				bootSuspend <= !pinAS && pinBSync;
			end
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	sequence s_fall;
		tckFall;
	endsequence

	property p_trst_low_reset;
		@(posedge ref_clk) disable iff (!reset_n)
		!trstS |=> state == ST_RESET;
	endproperty
	a_trst_low_reset: assert property (p_trst_low_reset) else $error("no reset on trst low");

	property p_state_step;
		@(posedge ref_clk) disable iff (!reset_n)
		(trstS && !tckRise) |=> state == $past(state);
	endproperty
	a_state_step: assert property (p_state_step) else $error("state moved without tck");

	property p_tdo_fall_only;
		@(posedge ref_clk) disable iff (!reset_n)
		!$past(tckFall) && $past(trstS) |-> $stable(tdo);
	endproperty
	a_tdo_fall_only: assert property (p_tdo_fall_only) else $error("tdo changed off fall");

	property p_ir_shift;
		@(posedge ref_clk) disable iff (!reset_n)
		(tckRise && state == ST_SH_IR && trstS) |=> irShift[IR_WIDTH-1] == $past(tdiS);
	endproperty
	a_ir_shift: assert property (p_ir_shift) else $error("tdi not shifted");

	property p_oe_trst;
		@(posedge ref_clk) disable iff (!reset_n)
		!trstS |=> !debug_event_pin_a_oe && !debug_event_pin_b_oe;
	endproperty
	a_oe_trst: assert property (p_oe_trst) else $error("pin driven in functional mode");

	property p_bscan;
		@(posedge ref_clk) disable iff (!reset_n)
		(trstRise && pinAS && !pinBSync) |=> boundaryScanMode;
	endproperty
	a_bscan: assert property (p_bscan) else $error("boundary scan not latched");

	property p_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		(releaseCnt == 2'h2 && !holdSampled) |=> boot_hold_waiting_mode == $past(!pinAS && pinBSync);
	endproperty
	a_hold: assert property (p_hold) else $error("hold mode mis-sampled");

	property p_suspend;
		@(posedge ref_clk) disable iff (!reset_n)
		bootSuspend == boot_hold_waiting_mode;
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend mismatch");

	// Once the boot is held it stays held until the next system reset.
	property p_suspend_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		bootSuspend |=> bootSuspend;
	endproperty
	a_suspend_hold: assert property (p_suspend_hold) else $error("suspend dropped");

	property p_tdo_en;
		@(posedge ref_clk) disable iff (!reset_n)
		s_fall ##0 (state == ST_IDLE) |=> !tdoEn;
	endproperty
	a_tdo_en: assert property (p_tdo_en) else $error("tdo enabled in idle");

endmodule : jtpe_tap

// file: bench/jtpe_probe_model.sv
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Debug probe model: paces the test port and drives emulation pins.
// -----------------------------------------------------------------
module jtpe_probe_model
	import jtpe_pkg::*;
(
	// Reference clock, pacing the test clock and every wait_ref delay the bench takes.
	input wire logic ref_clk,
	// Test port towards the device.
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst,
	input wire logic tdo,
	input wire logic tdoEn,
	// Device drive of the emulation pins and the resolved pin levels.
	input wire logic aOut,
	input wire logic aOe,
	input wire logic bOut,
	input wire logic bOe,
	output logic pinA,
	output logic pinB
);
	// Probe drive enables and values for the two pins.
	logic aDrv;
	logic aVal;
	logic bDrv;
	logic bVal;

	// The pull-ups decide a pin that nobody drives.
	assign pinA = aOe ? aOut : (aDrv ? aVal : 1'b1);
	assign pinB = bOe ? bOut : (bDrv ? bVal : 1'b1);

	// The test clock stands low between frames; test reset starts low.
	initial
	begin
		{tck, tms, tdi, trst} = 4'h2;
		{aDrv, aVal, bDrv, bVal} = 4'h0;
	end

	// Waits a number of reference edges, then steps just past the edge.
	task automatic wait_ref(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_ref

	// One test clock; the output is read late in the high phase, well after the falling update.
	// A bit read while the device does not enable its output comes back unknown.
	task automatic clk(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		wait_ref(4);
		tck = 1'b1;
		wait_ref(4);
		q = tdoEn ? tdo : 1'bx;
		tck = 1'b0;
	endtask : clk

	// Moves test reset; the probe is the only driver of the pin.
	task automatic set_trst(input logic v);
		trst = v;
	endtask : set_trst

	// One clock with mode select low, taking the controller from reset to idle.
	task automatic idle();
		logic q;
		clk(1'b0, 1'b0, q);
	endtask : idle

	// One scan from idle back to idle, least significant bit first.
	task automatic shift(input logic isIr, input int n, input logic [7:0] din,
		output logic [7:0] dout);
		logic q;
		dout = 8'h00;
		clk(1'b1, 1'b0, q);
		if (isIr)
			clk(1'b1, 1'b0, q);
		clk(1'b0, 1'b0, q);
		clk(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			clk(i == n - 1, din[i], q);
			dout[i] = q;
		end
		clk(1'b1, 1'b0, q);
		clk(1'b0, 1'b0, q);
	endtask : shift

	// Sets the probe's pin drive; callers settle pins before raising test reset.
	task automatic pins(input logic ad, input logic av, input logic bd, input logic bv);
		{aDrv, aVal, bDrv, bVal} = {ad, av, bd, bv};
	endtask : pins
endmodule : jtpe_probe_model

// file: bench/tb_jtag_tap_emulation_pins.sv
`timescale 1ns/1ps

module tb_jtag_tap_emulation_pins;
	import jtpe_pkg::*;
	// Clock, reset and pins.
	logic ref_clk, reset_n, tck, tms, tdi, trst, tdo, tdoEn;
	logic aOut, aOe, bOut, bOe, pinA, pinB, coreDebugIrqOut;
	logic irqA, irqB, scanMode, holdMode, bootSuspend;
	// Result counters.
	int errCount = 0;
	int numChecks = 0;
	logic [7:0] got;

	jtpe_tap u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
		.trst(trst), .tdo(tdo), .tdoEn(tdoEn), .debug_event_pin_a_in(pinA),
		.debug_event_pin_a_out(aOut), .debug_event_pin_a_oe(aOe),
		.debug_event_pin_b_in(pinB), .debug_event_pin_b_out(bOut),
		.debug_event_pin_b_oe(bOe), .coreDebugIrqOut(coreDebugIrqOut),
		.coreDebugIrqA(irqA), .coreDebugIrqB(irqB), .boundaryScanMode(scanMode),
		.boot_hold_waiting_mode(holdMode), .bootSuspend(bootSuspend));
	jtpe_probe_model u_probe (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi),
		.trst(trst), .tdo(tdo), .tdoEn(tdoEn), .aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe),
		.pinA(pinA), .pinB(pinB));

	// 10 MHz reference clock.
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Compares one result and counts it.
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
		numChecks++;
		if (seen !== exp)
		begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Reset for five cycles, then wait past the synchroniser fill.
	task automatic pulse_reset();
		reset_n = 1'b0;
		u_probe.wait_ref(5);
		reset_n = 1'b1;
		u_probe.wait_ref(6);
	endtask : pulse_reset

	// Pins a low and b high at reset exit hold the boot; released pins do not.
	task automatic t_boot_hold();
		u_probe.pins(1'b1, 1'b0, 1'b1, 1'b1);
		pulse_reset();
		check("hold", 8'h01, {7'h0, holdMode});
		check("suspend", 8'h01, {7'h0, bootSuspend});
		u_probe.pins(1'b0, 1'b0, 1'b0, 1'b0);
		pulse_reset();
		check("hold off", 8'h00, {7'h0, holdMode});
	endtask : t_boot_hold

	// After an IR scan the bypass bit delays data by one place.
	task automatic t_bypass();
		u_probe.idle();
		u_probe.shift(1'b1, IR_WIDTH, {4'h0, IR_BYPASS}, got);
		check("ir capture", {4'h0, IR_CAPTURE}, got);
		u_probe.shift(1'b0, 8, 8'hA5, got);
		check("bypass out", 8'h4A, got);
	endtask : t_bypass

	// Direction register turns the pins round in both directions.
	task automatic t_direction();
		u_probe.shift(1'b1, IR_WIDTH, {4'h0, IR_EMU_DIR}, got);
		u_probe.shift(1'b0, DR_WIDTH, 8'h03, got);
		// The probe pulls both pins low, so a high level proves the device drives them.
		u_probe.pins(1'b1, 1'b0, 1'b1, 1'b0);
		u_probe.wait_ref(6);
		check("pins high", 8'h03, {6'h0, pinB, pinA});
		coreDebugIrqOut = 1'b0;
		u_probe.wait_ref(6);
		check("pins driven", 8'h00, {6'h0, pinB, pinA});
		check("oe on", 8'h03, {6'h0, bOe, aOe});
		u_probe.shift(1'b0, DR_WIDTH, 8'h00, got);
		check("dir readback", 8'h03, got);
		u_probe.pins(1'b1, 1'b0, 1'b1, 1'b1);
		u_probe.wait_ref(6);
		check("irq in", 8'h02, {6'h0, irqB, irqA});
	endtask : t_direction

	// Low test reset releases the pins, then a rise with a high, b low latches scan mode.
	task automatic t_boundary();
		u_probe.set_trst(1'b0);
		u_probe.pins(1'b0, 1'b0, 1'b1, 1'b0);
		u_probe.wait_ref(6);
		check("released", 8'h00, {5'h0, tdoEn, bOe, aOe});
		check("scan idle", 8'h00, {7'h0, scanMode});
		u_probe.set_trst(1'b1);
		u_probe.wait_ref(6);
		check("scan on", 8'h01, {7'h0, scanMode});
		u_probe.idle();
		u_probe.shift(1'b0, 8, 8'h81, got);
		check("reset bypass", 8'h02, got);
	endtask : t_boundary

	// Prints the counts and the verdict, then stops.
	task automatic finalReport();
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finalReport

	// Main sequence.
	initial
	begin
		reset_n = 1'b0;
		coreDebugIrqOut = 1'b1;
		pulse_reset();
		check("status", 8'h00, {4'h0, tdoEn, scanMode, holdMode, bootSuspend});
		t_boot_hold();
		u_probe.set_trst(1'b1);
		t_bypass();
		t_direction();
		t_boundary();
		finalReport();
	end
endmodule : tb_jtag_tap_emulation_pins
